// file: verilog/dual_counter_waveform_capture.sv
/*
 * dual down-counter with waveform generation and edge capture, apb registers.
 * assumes one clock pclk, demod_in asynchronous, irq consumed elsewhere.
 */
// What this block does
// - disabled short output is inverse of its initial-level bit
// - short enable drives initial level, loads low or high reload
// - single-pass short counts to zero, stops, toggles, flags timeout
// - modulo-n short toggles at terminal count, reloads by new level
// - each modulo-n half-cycle sets timeout and may interrupt
// - reload registers writable anytime, used only at next load
// - short reload of zero wraps to ff, not a timeout
// - demod counting starts on first selected input edge
// - later edges capture inverted count, rising low, falling high
// - capture sets edge flag, may interrupt, reloads from high
// - demod zero sets timeout and continues from ff
// - disabled long output is inverse of its initial-level bit
// - output codes 10 and 11 force long output low or high
// - long enable loads high*256+low and drives initial level
// - long zero toggles, flags, may interrupt; modulo-n reloads
// - long reload of zero wraps to ffff, not a timeout
// - long demod edges capture count pair, reload and resume
// - ping-pong alternates short and long counters at terminal counts
`timescale 1ns/1ps
`default_nettype none
`include "dual_counter_params.svh"

module dual_counter_waveform_capture
    import dual_counter_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // waveform pins
    input wire logic demod_in,
    output logic short_counter_output,
    output logic long_counter_output,
    output logic short_irq,
    output logic long_irq
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] short_counter_control;
    logic [7:0] shared_counter_control;
    logic [7:0] long_counter_control;
    logic [7:0] short_reload_low;
    logic [7:0] short_reload_high;
    logic [7:0] long_reload_low_byte;
    logic [7:0] long_reload_high_byte;
    logic [7:0] short_capture_low;
    logic [7:0] short_capture_high;
    logic [7:0] long_capture_low_byte;
    logic [7:0] long_capture_high_byte;
    logic [7:0] short_count;
    logic [15:0] long_count;
    logic short_out;
    logic long_out;
    logic short_run;
    logic long_run;
    logic short_started;
    logic [2:0] sync;
    logic level;
    logic short_tick;
    logic long_tick;
    logic short_en_rise;
    logic long_en_rise;
    logic short_en_d;
    logic long_en_d;
    apb_req_t req;
    omode_t omode;

    assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
    assign omode = omode_t'(shared_counter_control[`BIT_OMODE_HI:`BIT_OMODE_LO]);

    wire demod = shared_counter_control[`BIT_DEMOD];
    wire wr = psel && penable && req.pwrite && pstrb[0] && clk_en;
    wire wr_short = wr && req.paddr == `ADDR_SHORT_CONTROL;
    wire wr_shared = wr && req.paddr == `ADDR_SHARED_CONTROL;
    wire wr_long = wr && req.paddr == `ADDR_LONG_CONTROL;
    wire short_en = short_counter_control[`BIT_ENABLE];
    wire long_en = long_counter_control[`BIT_ENABLE];
    wire pingpong = omode == omode_pingpong && !demod;

    function automatic logic addr_known(input logic [11:0] a);
        addr_known = a <= `ADDR_LONG_COUNT && a[1:0] == 2'b00 && a != 12'h00c
            && a != 12'h03c;
    endfunction

    function automatic logic edge_hit(input logic rise, input logic fall,
                                      input logic [7:0] sh);
        edge_hit = (rise && sh[`BIT_EDGE_LO]) || (fall && sh[`BIT_EDGE_HI]);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // three-stage input synchroniser
    // sampled on pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync <= 3'h0;
            level <= 1'b0;
        end else if (clk_en) begin
            sync <= {sync[1:0], demod_in};
            if (sync[1] == sync[2]) begin
                level <= sync[2];
            end
        end
    end

    wire agree = sync[1] == sync[2];
    wire rise = agree && sync[2] && !level;
    wire fall = agree && !sync[2] && level;
    wire sel_edge = edge_hit(rise, fall, shared_counter_control);

    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    assign pready = 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pslverr <= !addr_known(req.paddr);
                unique case (req.paddr)
                    `ADDR_SHORT_CONTROL: prdata <= {24'h0, short_counter_control};
                    `ADDR_SHARED_CONTROL: prdata <= {24'h0, shared_counter_control};
                    `ADDR_LONG_CONTROL: prdata <= {24'h0, long_counter_control};
                    `ADDR_SHORT_RELOAD_LOW: prdata <= {24'h0, short_reload_low};
                    `ADDR_SHORT_RELOAD_HIGH: prdata <= {24'h0, short_reload_high};
                    `ADDR_LONG_RELOAD_LOW: prdata <= {24'h0, long_reload_low_byte};
                    `ADDR_LONG_RELOAD_HIGH: prdata <= {24'h0, long_reload_high_byte};
                    `ADDR_SHORT_CAPTURE_LOW: prdata <= {24'h0, short_capture_low};
                    `ADDR_SHORT_CAPTURE_HIGH: prdata <= {24'h0, short_capture_high};
                    `ADDR_LONG_CAPTURE_LOW: prdata <= {24'h0, long_capture_low_byte};
                    `ADDR_LONG_CAPTURE_HIGH: prdata <= {24'h0, long_capture_high_byte};
                    `ADDR_SHORT_COUNT: prdata <= {24'h0, short_count};
                    `ADDR_LONG_COUNT: prdata <= {16'h0, long_count};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_reload_low <= `RESET_BYTE;
            short_reload_high <= `RESET_BYTE;
            long_reload_low_byte <= `RESET_BYTE;
            long_reload_high_byte <= `RESET_BYTE;
        end else if (wr) begin
            unique case (req.paddr)
                `ADDR_SHORT_RELOAD_LOW: short_reload_low <= req.pwdata[7:0];
                `ADDR_SHORT_RELOAD_HIGH: short_reload_high <= req.pwdata[7:0];
                `ADDR_LONG_RELOAD_LOW: long_reload_low_byte <= req.pwdata[7:0];
                `ADDR_LONG_RELOAD_HIGH: long_reload_high_byte <= req.pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shared_counter_control <= `RESET_BYTE;
        end else if (clk_en) begin
            if (wr_shared) begin
                shared_counter_control[7:2] <= req.pwdata[7:2];
                if (!demod) begin
                    shared_counter_control[1:0] <= req.pwdata[1:0];
                end
            end
            if (demod && wr_shared) begin
                shared_counter_control[`BIT_EDGE_POS] <=
                    shared_counter_control[`BIT_EDGE_POS] && !req.pwdata[`BIT_EDGE_POS];
                shared_counter_control[`BIT_EDGE_NEG] <=
                    shared_counter_control[`BIT_EDGE_NEG] && !req.pwdata[`BIT_EDGE_NEG];
            end
            if (demod && short_en && short_started && sel_edge) begin
                if (rise) shared_counter_control[`BIT_EDGE_POS] <= 1'b1;
                if (fall) shared_counter_control[`BIT_EDGE_NEG] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers: enable, mode, timeout flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_counter_control <= `RESET_BYTE;
        end else if (clk_en) begin
            if (wr_short) begin
                short_counter_control[7:6] <= req.pwdata[7:6];
                short_counter_control[4:0] <= req.pwdata[4:0];
                short_counter_control[`BIT_TIMEOUT] <=
                    short_counter_control[`BIT_TIMEOUT] && !req.pwdata[`BIT_TIMEOUT];
            end
            if (short_tick && !demod && short_counter_control[`BIT_SINGLE]) begin
                short_counter_control[`BIT_ENABLE] <= 1'b0;
            end
            if (pingpong && long_tick) begin
                short_counter_control[`BIT_ENABLE] <= 1'b1;
            end
            if (short_tick) begin
                short_counter_control[`BIT_TIMEOUT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            long_counter_control <= `RESET_BYTE;
        end else if (clk_en) begin
            if (wr_long) begin
                long_counter_control[7:6] <= req.pwdata[7:6];
                long_counter_control[4:0] <= req.pwdata[4:0];
                long_counter_control[`BIT_TIMEOUT] <=
                    long_counter_control[`BIT_TIMEOUT] && !req.pwdata[`BIT_TIMEOUT];
            end
            if (long_tick && !demod && long_counter_control[`BIT_SINGLE]) begin
                long_counter_control[`BIT_ENABLE] <= 1'b0;
            end
            if (pingpong && short_tick) begin
                long_counter_control[`BIT_ENABLE] <= 1'b1;
            end
            if (long_tick) begin
                long_counter_control[`BIT_TIMEOUT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_en_d <= 1'b0;
            long_en_d <= 1'b0;
        end else if (clk_en) begin
            short_en_d <= short_en;
            long_en_d <= long_en;
        end
    end

    assign short_en_rise = short_en && !short_en_d;
    assign long_en_rise = long_en && !long_en_d;
    assign short_tick = short_run && short_count == 8'h01 && clk_en;
    assign long_tick = long_run && long_count == 16'h0001 && clk_en;

    ////////////////////////////////////////////////////////////////////////
    // short counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_count <= `RESET_BYTE;
            short_out <= 1'b0;
            short_run <= 1'b0;
            short_started <= 1'b0;
            short_capture_low <= `RESET_BYTE;
            short_capture_high <= `RESET_BYTE;
        end else if (clk_en) begin
            if (!short_en) begin
                short_run <= 1'b0;
                short_started <= 1'b0;
            end else if (short_en_rise) begin
                short_out <= shared_counter_control[`BIT_SHORT_INIT];
                short_count <= shared_counter_control[`BIT_SHORT_INIT] ?
                    short_reload_high : short_reload_low;
                short_run <= !demod;
            end else if (demod) begin
                if (!short_started && sel_edge) begin
                    short_started <= 1'b1;
                    short_run <= 1'b1;
                end else if (short_started && sel_edge) begin
                    if (rise) short_capture_low <= ~short_count;
                    if (fall) short_capture_high <= ~short_count;
                    short_count <= short_reload_high;
                end else if (short_run) begin
                    short_count <= short_count - 8'h01;
                end
            end else if (short_tick) begin
                short_out <= !short_out;
                short_count <= short_out ? short_reload_low : short_reload_high;
                if (short_counter_control[`BIT_SINGLE]) begin
                    short_run <= 1'b0;
                end
            end else if (short_run) begin
                short_count <= short_count - 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // long counter
    wire [15:0] long_reload = {long_reload_high_byte, long_reload_low_byte};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            long_count <= `FULL_WORD;
            long_out <= 1'b0;
            long_run <= 1'b0;
            long_capture_low_byte <= `RESET_BYTE;
            long_capture_high_byte <= `RESET_BYTE;
        end else if (clk_en) begin
            if (!long_en) begin
                long_run <= 1'b0;
            end else if (long_en_rise) begin
                long_count <= long_reload;
                long_out <= shared_counter_control[`BIT_LONG_INIT];
                long_run <= !demod;
            end else if (demod) begin
                if (sel_edge) begin
                    {long_capture_high_byte, long_capture_low_byte} <= ~long_count;
                    long_count <= long_reload;
                    long_run <= 1'b1;
                end else if (long_run) begin
                    long_count <= long_count - 16'h0001;
                end
            end else if (long_tick) begin
                long_out <= !long_out;
                long_count <= long_reload;
                if (long_counter_control[`BIT_SINGLE]) begin
                    long_run <= 1'b0;
                end
            end else if (long_run) begin
                long_count <= long_count - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output pins and interrupts
    // output select
    // a pending enable shows the initial level, not a stale toggle state
    always_comb begin
        short_counter_output = short_en_rise ? shared_counter_control[`BIT_SHORT_INIT] :
            (short_en || short_run) ? short_out : !shared_counter_control[`BIT_SHORT_INIT];
        unique case (omode)
            omode_force0: long_counter_output = 1'b0;
            omode_force1: long_counter_output = 1'b1;
            default: long_counter_output = long_en_rise ?
                shared_counter_control[`BIT_LONG_INIT] : (long_en || long_run) ? long_out :
                !shared_counter_control[`BIT_LONG_INIT];
        endcase
    end

    assign short_irq = (short_counter_control[`BIT_TIMEOUT] &&
        short_counter_control[`BIT_TIMEOUT_IRQ_EN]) ||
        (demod && short_counter_control[`BIT_EDGE_IRQ_EN] &&
        |shared_counter_control[`BIT_EDGE_POS:`BIT_EDGE_NEG]);
    assign long_irq = long_counter_control[`BIT_TIMEOUT] &&
        long_counter_control[`BIT_TIMEOUT_IRQ_EN];

    ////////////////////////////////////////////////////////////////////////
    property p_short_timeout;
        @(posedge pclk) disable iff (!presetn)
        short_tick |=> short_counter_control[`BIT_TIMEOUT];
    endproperty
    a_short_timeout: assert property (p_short_timeout) else $error("short timeout lost");

    property p_short_toggle;
        @(posedge pclk) disable iff (!presetn)
        short_en && short_tick && !demod && !short_en_rise |=> short_out != $past(short_out);
    endproperty
    a_short_toggle: assert property (p_short_toggle) else $error("short no toggle");

    property p_short_load;
        @(posedge pclk) disable iff (!presetn)
        short_en_rise && clk_en |=> short_out == $past(shared_counter_control[1]);
    endproperty
    a_short_load: assert property (p_short_load) else $error("short init level");

    property p_long_force;
        @(posedge pclk) disable iff (!presetn)
        omode == omode_force1 |-> long_counter_output;
    endproperty
    a_long_force: assert property (p_long_force) else $error("long force");

    property p_long_idle;
        @(posedge pclk) disable iff (!presetn)
        !long_en && !long_run && omode == omode_normal |->
            long_counter_output == !shared_counter_control[0];
    endproperty
    a_long_idle: assert property (p_long_idle) else $error("long idle level");

    property p_long_timeout;
        @(posedge pclk) disable iff (!presetn)
        long_tick |=> long_counter_control[`BIT_TIMEOUT];
    endproperty
    a_long_timeout: assert property (p_long_timeout) else $error("long timeout lost");

    property p_pingpong;
        @(posedge pclk) disable iff (!presetn)
        pingpong && short_tick && !wr_long |=> long_en;
    endproperty
    a_pingpong: assert property (p_pingpong) else $error("ping-pong handover");

    property p_capture;
        @(posedge pclk) disable iff (!presetn)
        demod && short_en && short_started && rise && sel_edge && clk_en && !short_en_rise
            |=> short_capture_low == ~$past(short_count);
    endproperty
    a_capture: assert property (p_capture) else $error("short capture");

endmodule
`default_nettype wire

// file: verilog/dual_counter_params.svh
/*
 * register offsets, field positions and reset values of the dual counter block.
 * assumes a 32-bit apb slave with word-aligned registers.
 */
`ifndef DUAL_COUNTER_PARAMS_SVH
`define DUAL_COUNTER_PARAMS_SVH

`define ADDR_SHORT_CONTROL 12'h000
`define ADDR_SHARED_CONTROL 12'h004
`define ADDR_LONG_CONTROL 12'h008
`define ADDR_SHORT_RELOAD_LOW 12'h010
`define ADDR_SHORT_RELOAD_HIGH 12'h014
`define ADDR_LONG_RELOAD_LOW 12'h018
`define ADDR_LONG_RELOAD_HIGH 12'h01c
`define ADDR_SHORT_CAPTURE_LOW 12'h020
`define ADDR_SHORT_CAPTURE_HIGH 12'h024
`define ADDR_LONG_CAPTURE_LOW 12'h028
`define ADDR_LONG_CAPTURE_HIGH 12'h02c
`define ADDR_SHORT_COUNT 12'h030
`define ADDR_LONG_COUNT 12'h034

// counter control fields
`define BIT_ENABLE 7
`define BIT_SINGLE 6
`define BIT_TIMEOUT 5
`define BIT_EDGE_IRQ_EN 2
`define BIT_TIMEOUT_IRQ_EN 1
// shared control fields
`define BIT_DEMOD 7
`define BIT_EDGE_HI 5
`define BIT_EDGE_LO 4
`define BIT_OMODE_HI 3
`define BIT_OMODE_LO 2
`define BIT_SHORT_INIT 1
`define BIT_LONG_INIT 0
`define BIT_EDGE_POS 1
`define BIT_EDGE_NEG 0

`define RESET_BYTE 8'h00
`define FULL_BYTE 8'hff
`define FULL_WORD 16'hffff

`endif

// file: verilog/dual_counter_pkg.sv
/*
 * types shared by the dual counter block.
 * assumes nothing beyond the params header.
 */
package dual_counter_pkg;
    typedef enum logic [1:0] {
        omode_normal,
        omode_pingpong,
        omode_force0,
        omode_force1
    } omode_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic short_irq;
        logic long_irq;
    } irq_t;
endpackage

// file: tb/dual_counter_waveform_capture_tb.sv
/*
 * self-checking bench for the dual counter block, driven over apb.
 * assumes pready comes within 20 edges of the access phase and the design holds its own asserts.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dual_counter_params.svh"

module dual_counter_waveform_capture_tb
    import dual_counter_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, demod_in = 1'b0, pready, pslverr, so, lo, sirq, lirq, err;
    logic [3:0] pstrb = 4'hf;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int bad_count = 0, n_compared = 0, n;

    dual_counter_waveform_capture dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .demod_in(demod_in), .short_counter_output(so), .long_counter_output(lo),
        .short_irq(sirq), .long_irq(lirq));

    initial forever #20 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        if (bad_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            bad_count++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string what);
        apb(a, 1'b0, 32'h0);
        check(rd & m, e, what);
    endtask

    // counts edges until the chosen output reaches lvl; a hang ends the run
    task automatic wait_out(input bit long_side, input logic lvl);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
            if (n > 2000) begin
                bad_count++;
                give_verdict();
            end
        end while ((long_side ? lo : so) !== lvl);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_idle;
        check_bit(so, 1'b1, "short idle");
        check_bit(lo, 1'b1, "long idle");
        rdchk(`ADDR_LONG_COUNT, 32'hffffffff, 32'h0000ffff, "long count reset");
        wr(`ADDR_SHARED_CONTROL, 32'h03);
        @(negedge pclk);
        check_bit(so, 1'b0, "short idle, init set");
        check_bit(lo, 1'b0, "long idle, init set");
        wr(`ADDR_SHARED_CONTROL, 32'h08);
        @(negedge pclk);
        check_bit(lo, 1'b0, "forced low");
        wr(`ADDR_SHARED_CONTROL, 32'h0d);
        @(negedge pclk);
        check_bit(lo, 1'b1, "forced high");
        apb(12'h040, 1'b0, 32'h0);
        check_bit(err, 1'b1, "unmapped error");
        check(rd, 32'h0, "unmapped read");
        wr(`ADDR_SHARED_CONTROL, 32'h00);
    endtask

    task automatic t_single;
        wr(`ADDR_SHORT_RELOAD_LOW, 32'h05);
        wr(`ADDR_SHORT_RELOAD_HIGH, 32'h09);
        wr(`ADDR_SHORT_CONTROL, 32'hc2);
        @(negedge pclk);
        @(negedge pclk);
        check_bit(so, 1'b0, "short starts at init level");
        wait_out(1'b0, 1'b1);
        check(n, 5, "low reload used");
        rdchk(`ADDR_SHORT_CONTROL, 32'h20, 32'h20, "short timeout flag");
        check_bit(sirq, 1'b1, "short irq");
        repeat (20) @(posedge pclk);
        check_bit(so, 1'b1, "single pass stopped");
        wr(`ADDR_SHORT_CONTROL, 32'h00);
        wr(`ADDR_SHORT_CONTROL, 32'h20);
        rdchk(`ADDR_SHORT_CONTROL, 32'h20, 32'h00, "timeout cleared");
        check_bit(sirq, 1'b0, "short irq cleared");
    endtask

    task automatic t_modn;
        wr(`ADDR_SHORT_RELOAD_LOW, 32'h06);
        wr(`ADDR_SHORT_RELOAD_HIGH, 32'h0a);
        wr(`ADDR_SHORT_CONTROL, 32'h80);
        wait_out(1'b0, 1'b1);
        wait_out(1'b0, 1'b0);
        check(n, 10, "high half");
        wait_out(1'b0, 1'b1);
        check(n, 6, "low half");
        rdchk(`ADDR_SHORT_CONTROL, 32'h20, 32'h20, "half-cycle flag");
        // new high value lands before the next high load
        wr(`ADDR_SHORT_RELOAD_HIGH, 32'h0c);
        wait_out(1'b0, 1'b0);
        wait_out(1'b0, 1'b1);
        wait_out(1'b0, 1'b0);
        check(n, 12, "rewritten high half");
        wr(`ADDR_SHORT_CONTROL, 32'h00);
        wr(`ADDR_SHORT_CONTROL, 32'h20);
    endtask

    task automatic t_wrap;
        wr(`ADDR_SHORT_RELOAD_LOW, 32'h00);
        wr(`ADDR_SHORT_CONTROL, 32'hc0);
        wr(`ADDR_LONG_CONTROL, 32'hc0);
        repeat (30) @(posedge pclk);
        rdchk(`ADDR_SHORT_CONTROL, 32'h20, 32'h00, "wrap not timeout");
        check_bit(so, 1'b0, "no toggle on wrap");
        rdchk(`ADDR_LONG_CONTROL, 32'h20, 32'h00, "long wrap not timeout");
        check_bit(lo, 1'b0, "no long toggle on wrap");
        rdchk(`ADDR_SHORT_COUNT, 32'hc0, 32'hc0, "short wrapped past ff");
        rdchk(`ADDR_LONG_COUNT, 32'hff00, 32'hff00, "long wrapped past ffff");
        wr(`ADDR_SHORT_CONTROL, 32'h00);
        wr(`ADDR_LONG_CONTROL, 32'h00);
    endtask

    task automatic t_long;
        wr(`ADDR_LONG_RELOAD_LOW, 32'h02);
        wr(`ADDR_LONG_RELOAD_HIGH, 32'h01);
        wr(`ADDR_SHARED_CONTROL, 32'h01);
        wr(`ADDR_LONG_CONTROL, 32'h82);
        wait_out(1'b1, 1'b1);
        wait_out(1'b1, 1'b0);
        wait_out(1'b1, 1'b1);
        check(n, 258, "long half from high*256+low");
        rdchk(`ADDR_LONG_CONTROL, 32'h20, 32'h20, "long flag");
        check_bit(lirq, 1'b1, "long irq");
        wr(`ADDR_LONG_CONTROL, 32'h00);
        wr(`ADDR_LONG_CONTROL, 32'h20);
        wr(`ADDR_SHARED_CONTROL, 32'h00);
    endtask

    task automatic t_pingpong;
        wr(`ADDR_SHARED_CONTROL, 32'h04);
        wr(`ADDR_SHORT_RELOAD_LOW, 32'h14);
        wr(`ADDR_LONG_RELOAD_LOW, 32'h1e);
        wr(`ADDR_LONG_RELOAD_HIGH, 32'h00);
        wr(`ADDR_LONG_CONTROL, 32'h40);
        wr(`ADDR_SHORT_CONTROL, 32'hc0);
        wait_out(1'b0, 1'b1);
        rdchk(`ADDR_LONG_CONTROL, 32'h80, 32'h80, "long handed on");
        rdchk(`ADDR_SHORT_CONTROL, 32'h80, 32'h00, "short handed off");
        wait_out(1'b1, 1'b1);
        rdchk(`ADDR_SHORT_CONTROL, 32'h80, 32'h80, "short back on");
        wr(`ADDR_SHARED_CONTROL, 32'h00);
        wr(`ADDR_SHORT_CONTROL, 32'h00);
        wr(`ADDR_LONG_CONTROL, 32'h00);
        wr(`ADDR_SHORT_CONTROL, 32'h20);
        wr(`ADDR_LONG_CONTROL, 32'h20);
    endtask

    task automatic t_demod;
        wr(`ADDR_SHARED_CONTROL, 32'h90);
        wr(`ADDR_SHORT_RELOAD_LOW, 32'hff);
        wr(`ADDR_SHORT_RELOAD_HIGH, 32'hff);
        wr(`ADDR_LONG_RELOAD_LOW, 32'hff);
        wr(`ADDR_LONG_RELOAD_HIGH, 32'hff);
        wr(`ADDR_LONG_CONTROL, 32'h80);
        wr(`ADDR_SHORT_CONTROL, 32'h84);
        @(posedge pclk);
        demod_in <= 1'b1;
        repeat (5) @(posedge pclk);
        demod_in <= 1'b0;
        repeat (15) @(posedge pclk);
        demod_in <= 1'b1;
        repeat (8) @(posedge pclk);
        rdchk(`ADDR_SHARED_CONTROL, 32'h02, 32'h02, "rising edge flag");
        check_bit(sirq, 1'b1, "edge irq");
        apb(`ADDR_SHORT_CAPTURE_LOW, 1'b0, 32'h0);
        check_bit(rd >= 32'h12 && rd <= 32'h15, 1'b1, "inverted capture");
        rdchk(`ADDR_SHORT_CAPTURE_HIGH, 32'hff, 32'h00, "falling not selected");
        apb(`ADDR_LONG_CAPTURE_LOW, 1'b0, 32'h0);
        check_bit(rd >= 32'h12 && rd <= 32'h15, 1'b1, "long capture low");
        rdchk(`ADDR_LONG_CAPTURE_HIGH, 32'hff, 32'h00, "long capture high");
        repeat (250) @(posedge pclk);
        rdchk(`ADDR_SHORT_CONTROL, 32'h20, 32'h20, "demod timeout");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_idle();
        t_single();
        t_modn();
        t_wrap();
        t_long();
        t_pingpong();
        t_demod();
        give_verdict();
    end

    initial begin
        repeat (100000) @(posedge pclk);
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
